// file: logic/rtcc_cmd_ctrl.sv
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module rtcc_cmd_ctrl #(
	parameter int TALLY_W = 16,
	parameter int PTR_W = 32
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic rx_pkt_start,
	input wire logic rx_pkt_end,
	input wire logic rx_pkt_active,
	input wire logic net_active,
	input wire logic net_event,
	input wire logic atl_busy,
	input wire logic tx_load_done,
	input wire logic tx_frame_busy,
	input wire logic tx_desc_next,
	input wire logic [PTR_W-1:0] tx_desc_addr,
	input wire logic tx_eol_done,
	input wire rtcc_pkg::rtcc_tx_flags_t tx_flags,
	output logic rx_buffering,
	output logic tx_load,
	output logic tx_run,
	output logic [PTR_W-1:0] current_tx_descriptor_pointer
);
	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	logic wr_cmd;
	logic wr_stat;
	logic set_receive_enable_bit;
	logic set_receive_disable_bit;
	logic set_start;
	logic set_halt;
	logic abort_hit;
	logic halt_done;
	logic tx_end;
	logic receive_enable_bit_r;
	logic receive_disable_bit_r;
	logic rx_dis_last_r;
	logic transmit_start_bit_r;
	logic transmit_halt_bit_r;
	logic [TALLY_W-1:0] tally_r;
	logic [rtcc_pkg::ABORT_W-1:0] tx_stat_r;
	rtcc_pkg::rtcc_tx_state_t tx_state_r;

	assign wr_cmd = wr && (addr == rtcc_pkg::CMD_OFS);
	assign wr_stat = wr && (addr == rtcc_pkg::TXSTAT_OFS);
	assign set_receive_enable_bit = wr_cmd && wdata[rtcc_pkg::RECEIVE_ENABLE_BIT_BIT];
	assign set_receive_disable_bit = wr_cmd && wdata[rtcc_pkg::RECEIVE_DISABLE_BIT_BIT];
	// Start is dropped when it would collide with a table load, which would hang
	assign set_start = wr_cmd && wdata[rtcc_pkg::START_BIT] && !wdata[rtcc_pkg::ATL_BIT]
		&& !atl_busy && !transmit_start_bit_r;
	assign set_halt = wr_cmd && wdata[rtcc_pkg::HALT_BIT];
	assign abort_hit = |tx_flags;
	assign halt_done = transmit_halt_bit_r && (tx_state_r != rtcc_pkg::TX_IDLE)
		&& !tx_frame_busy;
	assign tx_end = (tx_state_r == rtcc_pkg::TX_RUN && tx_eol_done) || halt_done
		|| (tx_state_r != rtcc_pkg::TX_IDLE && abort_hit);

	// ---------------------------------------------------------------
	// Receive enable / disable interlock
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			receive_enable_bit_r <= 1'b0;
		end else if (set_receive_enable_bit) begin
			receive_enable_bit_r <= 1'b1;
		end else if (set_receive_disable_bit && !rx_pkt_active) begin
			receive_enable_bit_r <= 1'b0;
		end else if (receive_enable_bit_r && receive_disable_bit_r && !rx_pkt_active
			&& !net_active) begin
			// Both set: settle once the line is quiet; disable wins if it came last
			receive_enable_bit_r <= !rx_dis_last_r;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_dis_last_r <= 1'b0;
		end else if (set_receive_disable_bit) begin
			rx_dis_last_r <= 1'b1;
		end else if (set_receive_enable_bit) begin
			rx_dis_last_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			receive_disable_bit_r <= 1'b1;
		end else if (set_receive_disable_bit) begin
			receive_disable_bit_r <= 1'b1;
		end else if (set_receive_enable_bit && !rx_pkt_active && !net_active) begin
			receive_disable_bit_r <= 1'b0;
		end else if (receive_enable_bit_r && receive_disable_bit_r && !rx_dis_last_r
			&& !rx_pkt_active && !net_active) begin
			receive_disable_bit_r <= 1'b0;
		end
	end

	// Buffering is decided only at a frame's first cycle, never mid-frame
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_buffering <= 1'b0;
		end else if (rx_pkt_start) begin
			rx_buffering <= receive_enable_bit_r && !receive_disable_bit_r;
		end else if (rx_pkt_end) begin
			rx_buffering <= 1'b0;
		end
	end

	// Counts regardless of the receiver state; wraps
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tally_r <= '0;
		end else if (net_event) begin
			tally_r <= tally_r + 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Transmit command
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_state_r <= rtcc_pkg::TX_IDLE;
		end else begin
			case (tx_state_r)
				rtcc_pkg::TX_IDLE: begin
					if (set_start) begin
						tx_state_r <= rtcc_pkg::TX_LOAD;
					end
				end
				rtcc_pkg::TX_LOAD: begin
					if (tx_end) begin
						tx_state_r <= rtcc_pkg::TX_IDLE;
					end else if (tx_load_done) begin
						tx_state_r <= rtcc_pkg::TX_RUN;
					end
				end
				rtcc_pkg::TX_RUN: begin
					if (tx_end) begin
						tx_state_r <= rtcc_pkg::TX_IDLE;
					end
				end
				default: begin
					tx_state_r <= rtcc_pkg::TX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			transmit_start_bit_r <= 1'b0;
		end else if (set_start) begin
			transmit_start_bit_r <= 1'b1;
		end else if (tx_end) begin
			transmit_start_bit_r <= 1'b0;
		end
	end

	// A halt written while idle has nothing to stop and is dropped at once
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			transmit_halt_bit_r <= 1'b0;
		end else if (set_halt && transmit_start_bit_r) begin
			transmit_halt_bit_r <= 1'b1;
		end else if (tx_end || !transmit_start_bit_r) begin
			transmit_halt_bit_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_load <= 1'b0;
			tx_run <= 1'b0;
		end else begin
			tx_load <= set_start;
			tx_run <= (tx_state_r == rtcc_pkg::TX_RUN) && !tx_end;
		end
	end

	// Pointer only moves while running; the descriptor that ends under a halt is still
	// recorded, so a halt leaves the last processed one in place
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			current_tx_descriptor_pointer <= '0;
		end else if (tx_desc_next && tx_state_r == rtcc_pkg::TX_RUN) begin
			current_tx_descriptor_pointer <= tx_desc_addr;
		end
	end

	// Sticky abort causes; a new event beats a same-cycle clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_stat_r <= '0;
		end else begin
			tx_stat_r <= (wr_stat ? (tx_stat_r & ~wdata[rtcc_pkg::ABORT_W-1:0]) : tx_stat_r)
				| tx_flags;
		end
	end

	// ---------------------------------------------------------------
	// Read port
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= rtcc_pkg::RDATA_RST;
		end else if (!rd) begin
			rdata <= rtcc_pkg::RDATA_RST;
		end else if (addr == rtcc_pkg::CMD_OFS) begin
			rdata <= {22'h000000, atl_busy, 5'h00, receive_enable_bit_r,
				receive_disable_bit_r, transmit_start_bit_r, transmit_halt_bit_r};
		end else if (addr == rtcc_pkg::TALLY_OFS) begin
			rdata <= 32'(tally_r);
		end else if (addr == rtcc_pkg::CTDP_OFS) begin
			rdata <= 32'(current_tx_descriptor_pointer);
		end else if (addr == rtcc_pkg::TXSTAT_OFS) begin
			rdata <= 32'(tx_stat_r);
		end else begin
			rdata <= rtcc_pkg::RDATA_RST;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	a_receive_enable_bit_clears_dis: assert property (@(posedge clk) disable iff (!resetn)
		set_receive_enable_bit && !set_receive_disable_bit && !rx_pkt_active && !net_active |=> !receive_disable_bit_r)
		else $error("receive disable not cleared by idle enable");
	a_no_mid_buffer: assert property (@(posedge clk) disable iff (!resetn)
		$rose(rx_buffering) |-> $past(rx_pkt_start))
		else $error("buffering began mid packet");
	a_dis_stops_buf: assert property (@(posedge clk) disable iff (!resetn)
		rx_pkt_start && receive_disable_bit_r |=> !rx_buffering)
		else $error("disabled receiver buffered a packet");
	a_dis_holds_en: assert property (@(posedge clk) disable iff (!resetn)
		set_receive_disable_bit && !set_receive_enable_bit && receive_enable_bit_r && rx_pkt_active
		|=> receive_enable_bit_r && receive_disable_bit_r)
		else $error("enable dropped during packet");
	a_tally_counts: assert property (@(posedge clk) disable iff (!resetn)
		net_event |=> tally_r == $past(tally_r) + 1'b1)
		else $error("tally missed event");
	a_start_loads: assert property (@(posedge clk) disable iff (!resetn)
		set_start |=> tx_load && transmit_start_bit_r ##1 !tx_load)
		else $error("start did not pulse load");
	a_abort_clears: assert property (@(posedge clk) disable iff (!resetn)
		abort_hit && tx_state_r != rtcc_pkg::TX_IDLE |=> !transmit_start_bit_r && !tx_run)
		else $error("abort left start set");
	a_eol_clears: assert property (@(posedge clk) disable iff (!resetn)
		tx_state_r == rtcc_pkg::TX_RUN && tx_eol_done |=> tx_state_r == rtcc_pkg::TX_IDLE)
		else $error("end of list did not stop transmit");
	a_halt_waits: assert property (@(posedge clk) disable iff (!resetn)
		transmit_halt_bit_r && tx_frame_busy && !abort_hit && !tx_eol_done
		|=> transmit_start_bit_r)
		else $error("halt cut a frame short");
	a_halt_selfclr: assert property (@(posedge clk) disable iff (!resetn)
		halt_done |=> !transmit_halt_bit_r && !transmit_start_bit_r)
		else $error("halt bit not cleared");
	a_ptr_frozen: assert property (@(posedge clk) disable iff (!resetn)
		tx_state_r == rtcc_pkg::TX_IDLE |=> $stable(current_tx_descriptor_pointer))
		else $error("pointer moved while stopped");
	a_ptr_tracks: assert property (@(posedge clk) disable iff (!resetn)
		tx_desc_next && tx_state_r == rtcc_pkg::TX_RUN
		|=> current_tx_descriptor_pointer == $past(tx_desc_addr))
		else $error("processed descriptor not recorded");
	a_atl_blocks: assert property (@(posedge clk) disable iff (!resetn)
		!transmit_start_bit_r && atl_busy |=> !transmit_start_bit_r)
		else $error("start accepted during table load");
endmodule : rtcc_cmd_ctrl

// file: logic/rtcc_pkg.sv
package rtcc_pkg;
	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] CMD_OFS = 8'h00;
	localparam logic [7:0] TALLY_OFS = 8'h04;
	localparam logic [7:0] CTDP_OFS = 8'h08;
	localparam logic [7:0] TXSTAT_OFS = 8'h0c;

	// ---------------------------------------------------------------
	// Command register bit positions
	// ---------------------------------------------------------------
	localparam int HALT_BIT = 0;
	localparam int START_BIT = 1;
	localparam int RECEIVE_DISABLE_BIT_BIT = 2;
	localparam int RECEIVE_ENABLE_BIT_BIT = 3;
	localparam int ATL_BIT = 9;

	// Transmit status bit positions (write one to clear)
	localparam int EXC_BIT = 0;
	localparam int EXD_BIT = 1;
	localparam int FU_BIT = 2;
	localparam int BCM_BIT = 3;
	localparam int ABORT_W = 4;

	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_LOAD = 2'b01,
		TX_RUN = 2'b10
	} rtcc_tx_state_t;

	// Abort status flags reported by the transmit MAC, one-cycle pulses
	typedef struct packed {
		logic byte_count_mismatch_flag;
		logic fifo_underrun_flag;
		logic excessive_deferral_flag;
		logic excessive_collision_flag;
	} rtcc_tx_flags_t;
endpackage : rtcc_pkg

// file: test/rtcc_mac_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Transmit MAC and descriptor fetch stand-in
// ---------------------------------------------------------------
module rtcc_mac_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic tx_load,
	input wire logic tx_run,
	output logic tx_load_done,
	output logic tx_frame_busy,
	output logic tx_desc_next,
	output logic tx_eol_done,
	output logic [31:0] tx_desc_addr
);
	logic [3:0] cnt_r;
	logic [1:0] frm_r;
	logic [31:0] addr_r;
	logic ld_r;
	// Address is only meaningful with the strobe; show junk otherwise
	assign tx_desc_addr = tx_desc_next ? addr_r : ~addr_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			{cnt_r, frm_r, addr_r, ld_r} <= '0;
			{tx_load_done, tx_frame_busy, tx_desc_next, tx_eol_done} <= '0;
		end else begin
			tx_load_done <= 1'b0;
			tx_desc_next <= 1'b0;
			tx_eol_done <= 1'b0;
			if (tx_load) begin
				{ld_r, cnt_r, frm_r, tx_frame_busy} <= {1'b1, 4'h0, 2'h0, 1'b0};
			end else if (ld_r) begin
				cnt_r <= cnt_r + 4'h1;
				if (cnt_r == 4'h2) begin
					{ld_r, tx_load_done, cnt_r} <= {2'b01, 4'h0};
				end
			end else if (tx_run && !tx_eol_done) begin
				cnt_r <= (cnt_r == 4'h5) ? 4'h0 : cnt_r + 4'h1;
				tx_frame_busy <= cnt_r < 4'h4;
				if (cnt_r == 4'h4) begin
					tx_desc_next <= 1'b1;
					addr_r <= 32'h0000_1000 + {26'h0, frm_r, 4'h0};
					frm_r <= frm_r + 2'h1;
				end
				// Three frames then the list ends
				tx_eol_done <= cnt_r == 4'h5 && frm_r == 2'h3;
			end else begin
				{tx_frame_busy, cnt_r} <= '0;
			end
		end
	end
endmodule : rtcc_mac_model

// file: test/tb_rx_tx_command_control.sv
`timescale 1ns/1ps
module tb_rx_tx_command_control;
	logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, rx_pkt_start = 1'b0;
	logic rx_pkt_end = 1'b0, rx_pkt_active = 1'b0, net_active = 1'b0, net_event = 1'b0;
	logic atl_busy = 1'b0, tx_load_done, tx_frame_busy, tx_desc_next, tx_eol_done;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, tx_desc_addr, ptr;
	rtcc_pkg::rtcc_tx_flags_t tx_flags = '0;
	logic rx_buffering, tx_load, tx_run;
	int err_count = 0, cmp_count = 0, cyc = 0;
	rtcc_cmd_ctrl rtcc_cmd_ctrl_i (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .rx_pkt_start(rx_pkt_start), .rx_pkt_end(rx_pkt_end),
		.rx_pkt_active(rx_pkt_active), .net_active(net_active), .net_event(net_event),
		.atl_busy(atl_busy), .tx_load_done(tx_load_done), .tx_frame_busy(tx_frame_busy),
		.tx_desc_next(tx_desc_next), .tx_desc_addr(tx_desc_addr), .tx_eol_done(tx_eol_done),
		.tx_flags(tx_flags), .rx_buffering(rx_buffering), .tx_load(tx_load), .tx_run(tx_run),
		.current_tx_descriptor_pointer(ptr));
	rtcc_mac_model rtcc_mac_model_i (.clk(clk), .resetn(resetn), .tx_load(tx_load),
		.tx_run(tx_run), .tx_load_done(tx_load_done), .tx_frame_busy(tx_frame_busy),
		.tx_desc_next(tx_desc_next), .tx_eol_done(tx_eol_done), .tx_desc_addr(tx_desc_addr));
	always #20 clk = ~clk;
	// ---------------------------------------------------------------
	// Bus, stimulus and compare tasks
	// ---------------------------------------------------------------
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : wrap_up
	task automatic chk32(string nm, logic [31:0] exp, logic [31:0] act);
		cmp_count++;
		if (act !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, act);
		end
	endtask : chk32
	task automatic chk1(string nm, logic exp, logic act);
		cmp_count++;
		if (act !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %b seen %b", nm, exp, act);
		end
	endtask : chk1
	task automatic wr_reg(logic [7:0] a, logic [31:0] d);
		@(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
		@(posedge clk) wr <= 1'b0;
		#1;
	endtask : wr_reg
	task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] exp);
		@(posedge clk) {rd, addr} <= {1'b1, a};
		@(posedge clk) rd <= 1'b0;
		#1 chk32(nm, exp, rdata);
	endtask : rd_chk
	task automatic pkt(logic go);
		@(posedge clk) {rx_pkt_start, rx_pkt_end} <= {go, !go};
		@(posedge clk) {rx_pkt_start, rx_pkt_end, rx_pkt_active, net_active} <= {2'b00, go, go};
		#1;
	endtask : pkt
	task automatic wait_run(logic v);
		for (int i = 0; i < 60 && tx_run !== v; i++) @(posedge clk) #1;
		chk1("tx_run", v, tx_run);
	endtask : wait_run
	always @(posedge clk) if (++cyc == 5000) begin
		err_count++;
		wrap_up();
	end
	// ---------------------------------------------------------------
	// Test sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		rd_chk("cmd", rtcc_pkg::CMD_OFS, 32'h4);
		rd_chk("unmapped", 8'h40, 32'h0);
		wr_reg(rtcc_pkg::CMD_OFS, 32'h8);
		rd_chk("cmd", rtcc_pkg::CMD_OFS, 32'h8);
		pkt(1'b1);
		chk1("rx_buffering", 1'b1, rx_buffering);
		pkt(1'b0);
		wr_reg(rtcc_pkg::CMD_OFS, 32'h4);
		rd_chk("cmd", rtcc_pkg::CMD_OFS, 32'h4);
		pkt(1'b1);
		chk1("rx_buffering", 1'b0, rx_buffering);
		repeat (3) begin
			@(posedge clk) net_event <= 1'b1;
			@(posedge clk) net_event <= 1'b0;
		end
		// Enable lands mid-frame: this frame must stay unbuffered
		wr_reg(rtcc_pkg::CMD_OFS, 32'h8);
		rd_chk("cmd", rtcc_pkg::CMD_OFS, 32'hc);
		chk1("rx_buffering", 1'b0, rx_buffering);
		pkt(1'b0);
		rd_chk("cmd", rtcc_pkg::CMD_OFS, 32'h8);
		rd_chk("tally", rtcc_pkg::TALLY_OFS, 32'h3);
		pkt(1'b1);
		chk1("rx_buffering", 1'b1, rx_buffering);
		wr_reg(rtcc_pkg::CMD_OFS, 32'h4);
		rd_chk("cmd", rtcc_pkg::CMD_OFS, 32'hc);
		chk1("rx_buffering", 1'b1, rx_buffering);
		pkt(1'b0);
		rd_chk("cmd", rtcc_pkg::CMD_OFS, 32'h4);
		@(posedge clk) atl_busy <= 1'b1;
		wr_reg(rtcc_pkg::CMD_OFS, 32'h2);
		chk1("tx_load", 1'b0, tx_load);
		rd_chk("cmd", rtcc_pkg::CMD_OFS, 32'h204);
		@(posedge clk) atl_busy <= 1'b0;
		wr_reg(rtcc_pkg::CMD_OFS, 32'h202);
		rd_chk("cmd", rtcc_pkg::CMD_OFS, 32'h4);
		wr_reg(rtcc_pkg::CMD_OFS, 32'h2);
		chk1("tx_load", 1'b1, tx_load);
		rd_chk("cmd", rtcc_pkg::CMD_OFS, 32'h6);
		wait_run(1'b1);
		wait_run(1'b0);
		rd_chk("cmd", rtcc_pkg::CMD_OFS, 32'h4);
		rd_chk("pointer", rtcc_pkg::CTDP_OFS, 32'h0000_1020);
		chk32("ptr", 32'h0000_1020, ptr);
		wr_reg(rtcc_pkg::CMD_OFS, 32'h2);
		wait_run(1'b1);
		for (int i = 0; i < 20 && tx_frame_busy !== 1'b1; i++) @(posedge clk) #1;
		wr_reg(rtcc_pkg::CMD_OFS, 32'h1);
		chk1("tx_run", 1'b1, tx_run);
		wait_run(1'b0);
		rd_chk("cmd", rtcc_pkg::CMD_OFS, 32'h4);
		rd_chk("pointer", rtcc_pkg::CTDP_OFS, 32'h0000_1000);
		chk32("ptr", 32'h0000_1000, ptr);
		for (int i = 0; i < rtcc_pkg::ABORT_W; i++) begin
			wr_reg(rtcc_pkg::CMD_OFS, 32'h2);
			wait_run(1'b1);
			@(posedge clk) tx_flags <= rtcc_pkg::rtcc_tx_flags_t'(4'(1 << i));
			@(posedge clk) tx_flags <= '0;
			rd_chk("cmd", rtcc_pkg::CMD_OFS, 32'h4);
			chk1("tx_run", 1'b0, tx_run);
			rd_chk("txstat", rtcc_pkg::TXSTAT_OFS, 32'(1 << i));
			wr_reg(rtcc_pkg::TXSTAT_OFS, 32'hf);
		end
		rd_chk("txstat", rtcc_pkg::TXSTAT_OFS, 32'h0);
		wrap_up();
	end
endmodule : tb_rx_tx_command_control
